/* File: src/tsi_regs.svh */
`ifndef TSI_REGS_SVH
`define TSI_REGS_SVH
// Master clock and the musical-instrument link rate
`define TSI_CLK_HZ 25000000
`define TSI_MIDI_BPS 31250
// Baud ticks per asynchronous bit
`define TSI_OVS_N 16
`define TSI_OVS_LAST 4'hf
`define TSI_OVS_MID 4'h7
// Divider reload that gives the musical-instrument rate
`define TSI_MIDI_DIV (`TSI_CLK_HZ / (`TSI_MIDI_BPS * `TSI_OVS_N) - 1)
// Last bit index of a byte
`define TSI_LAST_BIT 3'h7
// Prescaler terminal count for the fxx/16 serial clock
`define TSI_PRE_LAST 3'h7
`endif

/* File: src/tsi_pkg.sv */
package tsi_pkg;
  // Shared sequencer states; END is stop bit or byte done
  typedef enum logic [1:0] {
    TSI_IDLE = 2'b00,
    TSI_START = 2'b01,
    TSI_DATA = 2'b10,
    TSI_END = 2'b11
  } tsi_st_t;
  // Synchronous channel clock source, {hi, lo}
  typedef enum logic [1:0] {
    TSI_SRC_T3 = 2'b00,
    TSI_SRC_D16 = 2'b01,
    TSI_SRC_D2 = 2'b10,
    TSI_SRC_D2B = 2'b11
  } tsi_src_t;
  typedef struct packed {
    tsi_st_t st;
    logic [3:0] ovs;
    logic [2:0] nbit;
    logic [7:0] sh;
    logic txd;
    logic sck;
    logic tx_rdy;
    logic irq;
    tsi_st_t rst;
    logic [3:0] rovs;
    logic [2:0] rbit;
    logic [7:0] rsh;
    logic rvld;
    logic [7:0] rdat;
    logic [7:0] bdiv;
    logic s1, s2, e1, e2, e3;
  } tsi_combo_t;
  typedef struct packed {
    tsi_st_t st;
    logic [2:0] nbit;
    logic [7:0] sh;
    logic sck, dout;
    logic ck_o, ck_oe_n, d_o, d_oe_n;
    logic tx_rdy, irq, rvld;
    logic [7:0] rdat;
    logic [2:0] pre;
    logic t3, i1, i2, a1, a2;
  } tsi_sync_t;
endpackage

/* File: src/tsi_top.sv */
// How it works
// - Three serial channels exist, two combined async/clocked and one sync.
// - All three channels run at once with no shared state between them.
// - Each combined channel picks async or three-wire mode on its own.
// - An async frame is one start bit, one data byte and a stop bit.
// - Each async channel has a divider, or counts ext baud pin edges.
// - The divider reaches the musical-instrument rate from the clock.
// - In three-wire mode this end drives the clock to start a byte.
// - Three-wire mode uses one clock line, one data in and one data out.
// - Each combined channel has its own three-wire interrupt pulse.
// - The sync channel drives its clock to move one byte per transfer.
// - Two-wire mode moves 8 bits over the clock and one shared data line.
// - Two-wire mode makes the clock and data pins open-drain.
// - Two select bits choose timer 3, fxx/16 or fxx/2 as sync clock.
// - The sync channel raises one interrupt pulse per finished byte.
`timescale 1ns/1ns
`include "tsi_regs.svh"

// Two-entry buffer on a receive path
module tsi_buf2 #(parameter int W = 8) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Fill side
  input wire logic [W-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // Drain side
  output logic [W-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  typedef struct packed {
    logic [1:0][W-1:0] d;
    logic [1:0] cnt;
    logic vld;
    logic rdy;
  } tsi_buf_st_t;
  tsi_buf_st_t q, next_q;

  // Pop shifts the head down, push lands behind the last word
  always_comb begin
    next_q = q;
    if (q.vld && out_ready_in) begin
      next_q.d[0] = q.d[1];
      next_q.cnt = q.cnt - 2'h1;
    end
    if (in_valid_in && q.rdy) begin
      next_q.d[next_q.cnt[0]] = in_data_in;
      next_q.cnt = next_q.cnt + 2'h1;
    end
    next_q.vld = next_q.cnt != 2'h0;
    next_q.rdy = next_q.cnt != 2'h2;
    if (sys_rst_in) begin
      next_q = '0;
      next_q.rdy = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    q <= next_q;
  end

  assign in_ready_out = q.rdy;
  assign out_data_out = q.d[0];
  assign out_valid_out = q.vld;
endmodule // tsi_buf2

// One combined channel: async link or three-wire master
module tsi_combo (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Mode and baud control
  input wire logic three_wire_shift_mode_in,
  input wire logic ext_baud_sel_in,
  input wire logic [7:0] baud_div_in,
  input wire logic ext_baud_clock_pin_in,
  // Serial pins
  input wire logic sin_in,
  output logic sout_out,
  output logic sck_out,
  // Transmit byte
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Received byte towards the buffer
  input wire logic buf_ready_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  // Interrupt pulse
  output logic irq_out
);
  import tsi_pkg::*;
  tsi_combo_t q, next_q;
  logic tick, accept, bit_end, rbit_end;

  always_comb begin
    next_q = q;
    next_q.irq = 1'b0;
    next_q.rvld = 1'b0;
    // Pins pass two flops before use
    next_q.s1 = sin_in;
    next_q.s2 = q.s1;
    next_q.e1 = ext_baud_clock_pin_in;
    next_q.e2 = q.e1;
    next_q.e3 = q.e2;
    // Baud tick from divider or external pin edge
    tick = 1'b0;
    if (ext_baud_sel_in) begin
      tick = q.e2 & ~q.e3;
    end else if (q.bdiv == 8'h00) begin
      tick = 1'b1;
      next_q.bdiv = baud_div_in;
    end else begin
      next_q.bdiv = q.bdiv - 8'h01;
    end
    accept = tx_valid_in & q.tx_rdy;
    bit_end = tick && q.ovs == `TSI_OVS_LAST;
    rbit_end = tick && q.rovs == `TSI_OVS_LAST;
    if (three_wire_shift_mode_in) begin
      // Master clock, MSB first, sample on the rising edge
      next_q.rst = TSI_IDLE;
      case (q.st)
        TSI_IDLE: if (accept) begin
          next_q.sh = tx_data_in;
          next_q.nbit = 3'h0;
          next_q.st = TSI_DATA;
        end
        TSI_DATA: if (tick) begin
          if (q.sck) begin
            next_q.sck = 1'b0;
            next_q.txd = q.sh[7];
          end else begin
            next_q.sck = 1'b1;
            next_q.sh = {q.sh[6:0], q.s2};
            next_q.nbit = q.nbit + 3'h1;
            if (q.nbit == `TSI_LAST_BIT) next_q.st = TSI_END;
          end
        end
        TSI_END: begin
          next_q.irq = 1'b1;
          next_q.rvld = 1'b1;
          next_q.rdat = q.sh;
          next_q.st = TSI_IDLE;
        end
        default: next_q.st = TSI_IDLE;
      endcase
    end else begin
      // Transmit: start, 8 data bits LSB first, stop
      if (tick && q.st != TSI_IDLE) next_q.ovs = q.ovs + 4'h1;
      case (q.st)
        TSI_IDLE: if (accept) begin
          next_q.sh = tx_data_in;
          next_q.st = TSI_START;
          next_q.txd = 1'b0;
          next_q.ovs = 4'h0;
        end
        TSI_START: if (bit_end) begin
          next_q.st = TSI_DATA;
          next_q.txd = q.sh[0];
          next_q.nbit = 3'h0;
        end
        TSI_DATA: if (bit_end) begin
          if (q.nbit == `TSI_LAST_BIT) begin
            next_q.st = TSI_END;
            next_q.txd = 1'b1;
          end else begin
            next_q.nbit = q.nbit + 3'h1;
            next_q.sh = q.sh >> 1;
            next_q.txd = q.sh[1];
          end
        end
        TSI_END: if (bit_end) next_q.st = TSI_IDLE;
        default: next_q.st = TSI_IDLE;
      endcase
      // Receive: check start at mid bit, then sample each mid bit
      if (tick && q.rst != TSI_IDLE) next_q.rovs = q.rovs + 4'h1;
      case (q.rst)
        TSI_IDLE: if (!q.s2) begin
          next_q.rst = TSI_START;
          next_q.rovs = 4'h0;
        end
        TSI_START: if (tick && q.rovs == `TSI_OVS_MID) begin
          next_q.rovs = 4'h0;
          next_q.rbit = 3'h0;
          next_q.rst = q.s2 ? TSI_IDLE : TSI_DATA;
        end
        TSI_DATA: if (rbit_end) begin
          next_q.rsh = {q.s2, q.rsh[7:1]};
          next_q.rbit = q.rbit + 3'h1;
          if (q.rbit == `TSI_LAST_BIT) next_q.rst = TSI_END;
        end
        TSI_END: if (rbit_end) begin
          // Framing error drops the byte; a full buffer drops it too
          next_q.rst = TSI_IDLE;
          next_q.rvld = q.s2;
          next_q.rdat = q.rsh;
        end
        default: next_q.rst = TSI_IDLE;
      endcase
    end
    // Clocked transfers wait for buffer room so no byte is lost
    next_q.tx_rdy = next_q.st == TSI_IDLE && (!three_wire_shift_mode_in ||
      (buf_ready_in && !q.rvld && !next_q.rvld));
    if (sys_rst_in) begin
      next_q = '0;
      next_q.txd = 1'b1;
      next_q.sck = 1'b1;
      // Synced line starts at its idle level, so no false start bit
      next_q.s1 = 1'b1;
      next_q.s2 = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    q <= next_q;
  end

  assign sout_out = q.txd;
  assign sck_out = q.sck;
  assign tx_ready_out = q.tx_rdy;
  assign rx_data_out = q.rdat;
  assign rx_valid_out = q.rvld;
  assign irq_out = q.irq;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  start_low_a: assert property (
    !three_wire_shift_mode_in && q.st == TSI_IDLE && accept
    |=> q.st == TSI_START && !q.txd ##1 !q.txd)
    else $error("async start bit not low");
  tw_start_a: assert property (
    three_wire_shift_mode_in && accept |=> q.st == TSI_DATA && q.sck)
    else $error("three-wire transfer did not start");
  tw_done_a: assert property (
    three_wire_shift_mode_in && q.st == TSI_DATA && tick && !q.sck &&
    q.nbit == `TSI_LAST_BIT |=> q.st == TSI_END ##1 irq_out && rx_valid_out)
    else $error("no interrupt after eighth clock");
  irq_cause_a: assert property (
    irq_out |-> $past(q.st) == TSI_END && $past(three_wire_shift_mode_in))
    else $error("interrupt without finished three-wire byte");
  ext_hold_a: assert property (
    ext_baud_sel_in && !three_wire_shift_mode_in && q.st == TSI_START &&
    q.e2 == q.e3 |=> $stable(q.ovs))
    else $error("baud advanced without pin edge");
  tw_hold_a: assert property (
    three_wire_shift_mode_in && q.st == TSI_IDLE && !buf_ready_in
    |=> !tx_ready_out ##1 q.st == TSI_IDLE)
    else $error("transfer started with full buffer");
  midi_c: cover property (
    !ext_baud_sel_in && baud_div_in == 8'(`TSI_MIDI_DIV) && rx_valid_out);
  tw_c: cover property (three_wire_shift_mode_in && irq_out);
endmodule // tsi_combo

module tsi_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Combined channels control
  input wire logic [1:0] three_wire_shift_mode_in,
  input wire logic [1:0] ext_baud_sel_in,
  input wire logic [1:0][7:0] baud_div_in,
  input wire logic [1:0] ext_baud_clock_pin_in,
  // Combined channels pins
  input wire logic [1:0] combo_sin_in,
  output logic [1:0] combo_sout_out,
  output logic [1:0] combo_sck_out,
  // Combined channels streams
  input wire logic [1:0][7:0] combo_tx_data_in,
  input wire logic [1:0] combo_tx_valid_in,
  output logic [1:0] combo_tx_ready_out,
  output logic [1:0][7:0] combo_rx_data_out,
  output logic [1:0] combo_rx_valid_out,
  input wire logic [1:0] combo_rx_ready_in,
  output logic combo_ch1_irq_out,
  output logic combo_ch2_irq_out,
  // Sync channel control
  input wire logic two_wire_mode_in,
  input wire logic clk_src_sel_lo_in,
  input wire logic clk_src_sel_hi_in,
  input wire logic timer3_out_in,
  // Sync channel pins
  input wire logic sync_channel_serial_in_in,
  input wire logic sync_channel_serial_out_in,
  output logic sync_channel_serial_out_out,
  output logic sync_channel_serial_out_oe_n_out,
  output logic sync_channel_clock_pin_out,
  output logic sync_channel_clock_pin_oe_n_out,
  // Sync channel streams
  input wire logic [7:0] sync_tx_data_in,
  input wire logic sync_tx_valid_in,
  output logic sync_tx_ready_out,
  output logic [7:0] sync_rx_data_out,
  output logic sync_rx_valid_out,
  input wire logic sync_rx_ready_in,
  output logic sync_channel_irq_out
);
  import tsi_pkg::*;
  tsi_sync_t q, next_q;
  tsi_src_t src;
  logic tick, sdi;
  logic [2:0][7:0] ch_d, out_d;
  logic [2:0] ch_v, buf_rdy, out_v, out_r;
  logic [1:0] irq;

  // Independent channels, each with its own receive buffer
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ch
      if (g < 2) begin : g_combo
        tsi_combo u_combo (
          .mclk_in(mclk_in),
          .sys_rst_in(sys_rst_in),
          .three_wire_shift_mode_in(three_wire_shift_mode_in[g]),
          .ext_baud_sel_in(ext_baud_sel_in[g]),
          .baud_div_in(baud_div_in[g]),
          .ext_baud_clock_pin_in(ext_baud_clock_pin_in[g]),
          .sin_in(combo_sin_in[g]),
          .sout_out(combo_sout_out[g]),
          .sck_out(combo_sck_out[g]),
          .tx_data_in(combo_tx_data_in[g]),
          .tx_valid_in(combo_tx_valid_in[g]),
          .tx_ready_out(combo_tx_ready_out[g]),
          .buf_ready_in(buf_rdy[g]),
          .rx_data_out(ch_d[g]),
          .rx_valid_out(ch_v[g]),
          .irq_out(irq[g])
        );
      end
      tsi_buf2 #(.W(8)) u_buf (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .in_data_in(ch_d[g]),
        .in_valid_in(ch_v[g]),
        .in_ready_out(buf_rdy[g]),
        .out_data_out(out_d[g]),
        .out_valid_out(out_v[g]),
        .out_ready_in(out_r[g])
      );
    end
  endgenerate

  assign out_r = {sync_rx_ready_in, combo_rx_ready_in};
  assign combo_rx_data_out = out_d[1:0];
  assign combo_rx_valid_out = out_v[1:0];
  assign sync_rx_data_out = out_d[2];
  assign sync_rx_valid_out = out_v[2];
  assign combo_ch1_irq_out = irq[0];
  assign combo_ch2_irq_out = irq[1];
  assign ch_d[2] = q.rdat;
  assign ch_v[2] = q.rvld;

  // Sync channel: master clock, MSB first
  always_comb begin
    next_q = q;
    next_q.irq = 1'b0;
    next_q.rvld = 1'b0;
    next_q.i1 = sync_channel_serial_in_in;
    next_q.i2 = q.i1;
    next_q.a1 = sync_channel_serial_out_in;
    next_q.a2 = q.a1;
    next_q.t3 = timer3_out_in;
    next_q.pre = q.pre + 3'h1;
    src = tsi_src_t'({clk_src_sel_hi_in, clk_src_sel_lo_in});
    case (src)
      TSI_SRC_T3: tick = timer3_out_in & ~q.t3;
      TSI_SRC_D16: tick = q.pre == `TSI_PRE_LAST;
      default: tick = 1'b1;
    endcase
    // Two-wire receives from the shared data line
    sdi = two_wire_mode_in ? q.a2 : q.i2;
    case (q.st)
      TSI_IDLE: if (sync_tx_valid_in && q.tx_rdy) begin
        next_q.sh = sync_tx_data_in;
        next_q.nbit = 3'h0;
        next_q.st = TSI_DATA;
      end
      TSI_DATA: if (tick) begin
        if (q.sck) begin
          next_q.sck = 1'b0;
          next_q.dout = q.sh[7];
        end else begin
          next_q.sck = 1'b1;
          next_q.sh = {q.sh[6:0], sdi};
          next_q.nbit = q.nbit + 3'h1;
          if (q.nbit == `TSI_LAST_BIT) next_q.st = TSI_END;
        end
      end
      TSI_END: begin
        next_q.irq = 1'b1;
        next_q.rvld = 1'b1;
        next_q.rdat = q.sh;
        next_q.dout = 1'b1;
        next_q.st = TSI_IDLE;
      end
      default: next_q.st = TSI_IDLE;
    endcase
    next_q.tx_rdy = next_q.st == TSI_IDLE && buf_rdy[2] && !q.rvld &&
      !next_q.rvld;
    // Open-drain pulls low only; a high level is released
    next_q.ck_o = two_wire_mode_in ? 1'b0 : next_q.sck;
    next_q.ck_oe_n = two_wire_mode_in ? next_q.sck : 1'b0;
    next_q.d_o = two_wire_mode_in ? 1'b0 : next_q.dout;
    next_q.d_oe_n = two_wire_mode_in ? next_q.dout : 1'b0;
    if (sys_rst_in) begin
      next_q = '0;
      next_q.sck = 1'b1;
      next_q.dout = 1'b1;
      next_q.ck_o = 1'b1;
      next_q.d_o = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    q <= next_q;
  end

  assign sync_channel_clock_pin_out = q.ck_o;
  assign sync_channel_clock_pin_oe_n_out = q.ck_oe_n;
  assign sync_channel_serial_out_out = q.d_o;
  assign sync_channel_serial_out_oe_n_out = q.d_oe_n;
  assign sync_tx_ready_out = q.tx_rdy;
  assign sync_channel_irq_out = q.irq;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  od_low_a: assert property (
    two_wire_mode_in |=> !sync_channel_clock_pin_out &&
    !sync_channel_serial_out_out)
    else $error("open-drain pin driven high");
  d2_rate_a: assert property (
    src == TSI_SRC_D2 && q.st == TSI_DATA && q.nbit != `TSI_LAST_BIT
    |=> q.sck != $past(q.sck))
    else $error("fxx/2 clock did not toggle");
  // Push pulse first; an older word may already stand at the drain side
  sync_irq_a: assert property (
    q.st == TSI_END |=> sync_channel_irq_out && ch_v[2] ##1
    sync_rx_valid_out)
    else $error("sync byte not signalled");
  tw_c: cover property (two_wire_mode_in && sync_channel_irq_out);
  all_c: cover property (
    q.st == TSI_DATA && !combo_sck_out[0] && !combo_sout_out[1]);
endmodule // tsi_top

/* File: verif/tsi_peer.sv */
`timescale 1ns/1ns
// Far-side serial device: async 8N1 peer or clocked slave
module tsi_peer #(parameter int BIT_NS = 32000) (
  // Mode
  input wire logic clocked_in,
  input wire logic od_in,
  // Lines
  input wire logic line_in,
  input wire logic sck_in,
  output logic line_out
);
  logic [7:0] got, reply, sh;
  logic armed;
  int ngot, nbit;
  // Idle high, as a pulled-up line would sit
  initial begin
    line_out = 1'b1;
    got = 8'h00;
    reply = 8'h5a;
    sh = 8'h00;
    armed = 1'b0;
    ngot = 0;
    nbit = 0;
  end
  // Async receive; start bit rechecked at mid-bit to reject glitches
  always @(negedge line_in) begin
    if (!clocked_in) begin
      #(BIT_NS / 2);
      if (!line_in) begin
        for (int i = 0; i < 8; i++) begin
          #(BIT_NS);
          sh[i] = line_in;
        end
        #(BIT_NS);
        if (line_in) begin
          got = sh;
          ngot++;
        end
      end
    end
  end
  // Async send: start, byte LSB first, stop
  task automatic send(input logic [7:0] b);
    line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      line_out = b[i];
      #(BIT_NS);
    end
    line_out = 1'b1;
    #(BIT_NS);
  endtask
  // Slave presents MSB first once the master drops the clock
  always @(negedge sck_in) begin
    if (clocked_in) begin
      line_out = reply[3'h7 - nbit[2:0]];
      armed = 1'b1;
    end
  end
  // Sample on rising clock; afterwards release or invert so no stale bit
  // Power-up X-to-1 on the clock is no edge: count only after a fall
  always @(posedge sck_in) begin
    if (clocked_in && armed) begin
      sh = {sh[6:0], line_in};
      nbit++;
      if (nbit == 8) begin
        got = sh;
        ngot++;
        nbit = 0;
        reply++;
        line_out = od_in ? 1'b1 : ~line_out;
      end
    end
  end
endmodule // tsi_peer

/* File: verif/triple_serial_interface_tb.sv */
`timescale 1ns/1ns
module triple_serial_interface_tb;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [1:0] mode = 2'b00, esel = 2'b00, epin = 2'b00;
  logic [1:0][7:0] bdiv = {8'h07, 8'h31};
  logic [2:0][7:0] txd = '0;
  logic [2:0] txv = 3'h0, rxr = 3'h0;
  logic two = 1'b0, sel_lo = 1'b0, sel_hi = 1'b0, t3 = 1'b0;
  wire [1:0] csin, csout, csck;
  wire [2:0] txr, rxv, irq;
  wire [2:0][7:0] rxd;
  wire so, so_oe_n, ck, ck_oe_n, ps_out, sda, scl;
  int mismatches = 0;
  int compares = 0;
  int irqn[3] = '{0, 0, 0};
  // Open-drain wires: released means pulled high, any low wins
  assign sda = (so_oe_n ? 1'b1 : so) & (two ? ps_out : 1'b1);
  // Delay filters the zero-width blip when both pin fields switch mode
  assign #1 scl = ck_oe_n ? 1'b1 : ck;

  tsi_top i_tsi_top (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .three_wire_shift_mode_in(mode), .ext_baud_sel_in(esel),
    .baud_div_in(bdiv), .ext_baud_clock_pin_in(epin),
    .combo_sin_in(csin), .combo_sout_out(csout), .combo_sck_out(csck),
    .combo_tx_data_in(txd[1:0]), .combo_tx_valid_in(txv[1:0]),
    .combo_tx_ready_out(txr[1:0]), .combo_rx_data_out(rxd[1:0]),
    .combo_rx_valid_out(rxv[1:0]), .combo_rx_ready_in(rxr[1:0]),
    .combo_ch1_irq_out(irq[0]), .combo_ch2_irq_out(irq[1]),
    .two_wire_mode_in(two), .clk_src_sel_lo_in(sel_lo),
    .clk_src_sel_hi_in(sel_hi), .timer3_out_in(t3),
    .sync_channel_serial_in_in(ps_out), .sync_channel_serial_out_in(sda),
    .sync_channel_serial_out_out(so),
    .sync_channel_serial_out_oe_n_out(so_oe_n),
    .sync_channel_clock_pin_out(ck),
    .sync_channel_clock_pin_oe_n_out(ck_oe_n),
    .sync_tx_data_in(txd[2]), .sync_tx_valid_in(txv[2]),
    .sync_tx_ready_out(txr[2]), .sync_rx_data_out(rxd[2]),
    .sync_rx_valid_out(rxv[2]), .sync_rx_ready_in(rxr[2]),
    .sync_channel_irq_out(irq[2]));
  // Peers: ch0 at the divider rate, ch1 at ext pin rate (16 x 320 ns)
  // Two-wire is off whenever the combined peers are in use
  tsi_peer i_p0 (.clocked_in(mode[0]), .od_in(two),
    .line_in(csout[0]), .sck_in(csck[0]), .line_out(csin[0]));
  tsi_peer #(.BIT_NS(5120)) i_p1 (.clocked_in(mode[1]), .od_in(two),
    .line_in(csout[1]), .sck_in(csck[1]), .line_out(csin[1]));
  tsi_peer i_ps (.clocked_in(1'b1), .od_in(two),
    .line_in(sda), .sck_in(scl), .line_out(ps_out));

  // Clock
  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  // Ext baud pins and timer 3 toggle every 4 clocks
  initial begin
    forever begin
      repeat (4) @(negedge mclk_in);
      epin = ~epin;
      t3 = ~t3;
    end
  end
  // Interrupt pulse counters; a stuck level shows as a count above one
  // Sampled mid-cycle, where the registered pulse has settled
  always @(negedge mclk_in) begin
    for (int i = 0; i < 3; i++) if (irq[i] === 1'b1) irqn[i]++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("FAIL %0t wait limit reached", $time);
    conclude();
  endtask
  // Byte handed over only while ready is seen high
  task automatic put_tx(input int ch, input logic [7:0] d);
    int n;
    for (n = 0; n < 20000 && txr[ch] !== 1'b1; n++) @(negedge mclk_in);
    if (n == 20000) timeout();
    txd[ch] = d;
    txv[ch] = 1'b1;
    @(negedge mclk_in);
    txv[ch] = 1'b0;
  endtask
  task automatic get_rx(input int ch, input logic [7:0] exp);
    int n;
    for (n = 0; n < 20000 && rxv[ch] !== 1'b1; n++) @(negedge mclk_in);
    if (n == 20000) timeout();
    check(rxd[ch], exp);
    rxr[ch] = 1'b1;
    @(negedge mclk_in);
    rxr[ch] = 1'b0;
    // Let an edge pass so a following call never re-raises ready at once
    @(negedge mclk_in);
  endtask

  task automatic reset_values();
    check({4'h0, csout, csck}, 8'h0f);
    check({2'h0, irq, rxv}, 8'h00);
    check({4'h0, so, ck, so_oe_n, ck_oe_n}, 8'h0c);
  endtask
  // Both async channels at once, divider and ext pin
  task automatic async_both();
    int n;
    esel = 2'b10;
    fork
      put_tx(0, 8'ha5);
      put_tx(1, 8'h3c);
    join
    for (n = 0; n < 9000 && txr[0] !== 1'b1; n++) @(negedge mclk_in);
    if (n == 9000) timeout();
    check({7'h00, n >= 7950 && n <= 8060}, 8'h01);
    check(i_p0.got, 8'ha5);
    check(i_p1.got, 8'h3c);
    fork
      i_p0.send(8'h96);
      i_p1.send(8'h69);
    join
    @(negedge mclk_in);
    get_rx(0, 8'h96);
    get_rx(1, 8'h69);
  endtask
  // Three-wire on each channel alone; only its own interrupt pulses
  task automatic three_wire_irq();
    int b0, b1;
    logic [7:0] r;
    mode = 2'b11;
    esel = 2'b00;
    bdiv = {8'h07, 8'h07};
    @(negedge mclk_in);
    for (int c = 0; c < 2; c++) begin
      b0 = irqn[0];
      b1 = irqn[1];
      r = c ? i_p1.reply : i_p0.reply;
      put_tx(c, 8'hc3 ^ 8'(c));
      get_rx(c, r);
      check(c ? i_p1.got : i_p0.got, 8'hc3 ^ 8'(c));
      check({4'(irqn[0] - b0), 4'(irqn[1] - b1)}, c ? 8'h01 : 8'h10);
    end
  endtask
  // Receiver stalls: two bytes held, third refused until drained
  task automatic buffer_fill();
    int n, b;
    logic [7:0] r;
    r = i_p0.reply;
    b = irqn[0];
    put_tx(0, 8'h11);
    put_tx(0, 8'h22);
    for (n = 0; n < 2000 && irqn[0] < b + 2; n++) @(negedge mclk_in);
    if (n == 2000) timeout();
    repeat (4) @(negedge mclk_in);
    check({7'h00, txr[0]}, 8'h00);
    get_rx(0, r);
    get_rx(0, r + 8'h01);
    put_tx(0, 8'h33);
    get_rx(0, r + 8'h02);
    check({7'h00, rxv[0]}, 8'h00);
  endtask
  // Sync channel over every clock source, three-wire and two-wire
  task automatic sync_modes();
    logic [2:0] cfg[5] = '{3'b000, 3'b001, 3'b101, 3'b110, 3'b011};
    int half[5] = '{8, 8, 8, 1, 1};
    int n, b;
    logic [7:0] r, d;
    for (int k = 0; k < 5; k++) begin
      {two, sel_hi, sel_lo} = cfg[k];
      @(negedge mclk_in);
      r = i_ps.reply;
      d = 8'h5a + 8'(k);
      b = irqn[2];
      put_tx(2, d);
      for (n = 0; n < 100 && scl !== 1'b0; n++) @(negedge mclk_in);
      if (n == 100) timeout();
      for (n = 0; n < 100 && scl === 1'b0; n++) @(negedge mclk_in);
      if (n == 100) timeout();
      check(8'(n), 8'(half[k]));
      for (n = 0; n < 1000 && irqn[2] == b; n++) @(negedge mclk_in);
      if (n == 1000) timeout();
      repeat (2) @(negedge mclk_in);
      check(8'(irqn[2] - b), 8'h01);
      check(i_ps.got, two ? d & r : d);
      // Fast sources only drained: readback path adds sync latency
      if (half[k] == 8) get_rx(2, two ? d & r : r);
      else begin
        rxr[2] = 1'b1;
        @(negedge mclk_in);
        rxr[2] = 1'b0;
      end
      check({6'h00, ck_oe_n, so_oe_n}, two ? 8'h03 : 8'h00);
      if (two) check({6'h00, ck, so}, 8'h00);
    end
  endtask

  // Main sequence
  initial begin
    repeat (9) @(negedge mclk_in);
    reset_values();
    @(negedge mclk_in);
    sys_rst_in = 1'b0;
    async_both();
    three_wire_irq();
    buffer_fill();
    sync_modes();
    conclude();
  end
endmodule // triple_serial_interface_tb
